/* src/xie_regs.svh */
// constants for the peripheral interrupt enable register
// assumes an 8-bit special-function register bus with an 8-bit address
//
// Behaviour
// - bit 7 passes timer three low or high overflow requests
// - bit 5 passes comparator rising or falling requests
// - bit 4 passes all counter array requests
// - bit 3 passes conversion done request
// - bit 2 passes window compare request
// - bit 1 passes clock alarm request
// - bit 0 passes all two-wire port requests
`ifndef XIE_REGS_SVH
`define XIE_REGS_SVH
`define XIE_ENABLE_ADDR 8'hE6
`define XIE_ENABLE_RESET 8'h00
`define XIE_WRITE_MASK 8'hBF
`define XIE_BIT_TIMER 7
`define XIE_BIT_COMPARATOR 5
`define XIE_BIT_COUNTER 4
`define XIE_BIT_CONV_DONE 3
`define XIE_BIT_WINDOW 2
`define XIE_BIT_ALARM 1
`define XIE_BIT_TWOWIRE 0
`endif

/* src/xie_pkg.sv */
// types for the peripheral interrupt enable register
// assumes the constants header is included by users of the bit positions
`default_nettype none
package xie_pkg;
  // raw source flags as raised by the peripherals
  typedef struct packed {
    logic timer_three_low_overflow_flag;
    logic timer_three_high_overflow_flag;
    logic comparator_rising_flag;
    logic comparator_falling_flag;
    logic counter_array;
    logic conversion_done_flag;
    logic window_compare_flag;
    logic clock_alarm;
    logic twowire_port;
  } xie_flags_s;
  // gated requests toward the processor interrupt logic
  typedef struct packed {
    logic timer_three;
    logic comparator;
    logic counter_array;
    logic conversion_done;
    logic window_compare;
    logic clock_alarm;
    logic twowire_port;
  } xie_req_s;
endpackage : xie_pkg
`default_nettype wire

/* src/xie_enable_one.sv */
// peripheral interrupt enable register one and its request gating
// holds seven source enables and ands each one with the flags of its source
// assumes the sfr bus and the flags are synchronous to clock
// assumes each flag is a level that its peripheral holds until it is cleared
`include "xie_regs.svh"
`default_nettype none

module xie_enable_one
  import xie_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // special-function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // peripheral flags
  input var xie_flags_s flags,
  // gated requests and register contents
  output var xie_req_s req,
  output logic [7:0] enable_bits
);

  // ==========================================
  // field positions

  localparam int TIMER_POS = `XIE_BIT_TIMER;
  localparam int COMPARATOR_POS = `XIE_BIT_COMPARATOR;
  localparam int COUNTER_POS = `XIE_BIT_COUNTER;
  localparam int CONV_DONE_POS = `XIE_BIT_CONV_DONE;
  localparam int WINDOW_POS = `XIE_BIT_WINDOW;
  localparam int ALARM_POS = `XIE_BIT_ALARM;
  localparam int TWOWIRE_POS = `XIE_BIT_TWOWIRE;

  // ==========================================
  // helper functions

  // no page term in the decode: the register answers on every page
  function automatic logic xie_addr_hit(
    input logic [7:0] addr
  );
    return addr == `XIE_ENABLE_ADDR;
  endfunction : xie_addr_hit

  // the unused bit never stores a one, so it always reads back zero
  function automatic logic [7:0] xie_store_value(
    input logic [7:0] data
  );
    return data & `XIE_WRITE_MASK;
  endfunction : xie_store_value

  // other addresses read zero so that several registers can share one read bus
  function automatic logic [7:0] xie_read_value(
    input logic hit,
    input logic [7:0] value
  );
    logic [7:0] result;
    result = 8'h00;
    if (hit) begin
      result = value;
    end
    return result;
  endfunction : xie_read_value

  // one enable bit picked out of the register
  function automatic logic xie_field(
    input logic [7:0] value,
    input int pos
  );
    return value[pos];
  endfunction : xie_field

  // a source with a single flag
  function automatic logic xie_gate_one(
    input logic enable,
    input logic flag
  );
    return enable & flag;
  endfunction : xie_gate_one

  // a source with two flags raises one shared request
  function automatic logic xie_gate_two(
    input logic enable,
    input logic flag_a,
    input logic flag_b
  );
    logic any_flag;
    any_flag = flag_a | flag_b;
    return enable & any_flag;
  endfunction : xie_gate_two

  // ==========================================
  // address decode

  logic addr_match;
  logic write_hit;

  assign addr_match = xie_addr_hit(sfr_addr);
  assign write_hit = sfr_wr & addr_match;

  // ==========================================
  // enable register

  logic [7:0] peripheral_irq_enable_one_reg;
  logic [7:0] peripheral_irq_enable_one_next;

  // one write per cycle; the new value shows from the next cycle on
  always_comb begin
    peripheral_irq_enable_one_next = peripheral_irq_enable_one_reg;
    if (write_hit) begin
      peripheral_irq_enable_one_next = xie_store_value(sfr_wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      peripheral_irq_enable_one_reg <= `XIE_ENABLE_RESET;
    end else begin
      peripheral_irq_enable_one_reg <= peripheral_irq_enable_one_next;
    end
  end

  // ==========================================
  // read path

  // read data is combinational so the value is taken in the cycle of the access
  assign sfr_hit = addr_match;
  assign sfr_rdata = xie_read_value(addr_match, peripheral_irq_enable_one_reg);
  assign enable_bits = peripheral_irq_enable_one_reg;

  // ==========================================
  // enable fields

  logic timer_three_irq_enable;
  logic comparator_irq_enable;
  logic counter_array_irq_enable;
  logic conversion_done_irq_enable;
  logic window_compare_irq_enable;
  logic clock_alarm_irq_enable;
  logic twowire_port_irq_enable;

  // each enable is a plain register bit; nothing else qualifies it here
  assign timer_three_irq_enable =
    xie_field(peripheral_irq_enable_one_reg, TIMER_POS);

  assign comparator_irq_enable =
    xie_field(peripheral_irq_enable_one_reg, COMPARATOR_POS);

  assign counter_array_irq_enable =
    xie_field(peripheral_irq_enable_one_reg, COUNTER_POS);

  assign conversion_done_irq_enable =
    xie_field(peripheral_irq_enable_one_reg, CONV_DONE_POS);

  assign window_compare_irq_enable =
    xie_field(peripheral_irq_enable_one_reg, WINDOW_POS);

  assign clock_alarm_irq_enable =
    xie_field(peripheral_irq_enable_one_reg, ALARM_POS);

  assign twowire_port_irq_enable =
    xie_field(peripheral_irq_enable_one_reg, TWOWIRE_POS);

  // ==========================================
  // request gating

  // no latching here: the peripheral keeps a masked flag set, so the request
  // appears as soon as software sets the enable; clearing stays with the source
  logic timer_three_req;
  logic comparator_req;
  logic counter_array_req;
  logic conversion_done_req;
  logic window_compare_req;
  logic clock_alarm_req;
  logic twowire_port_req;

  always_comb begin
    timer_three_req = xie_gate_two(timer_three_irq_enable,
      flags.timer_three_low_overflow_flag, flags.timer_three_high_overflow_flag);

    comparator_req = xie_gate_two(comparator_irq_enable,
      flags.comparator_rising_flag, flags.comparator_falling_flag);

    counter_array_req = xie_gate_one(counter_array_irq_enable, flags.counter_array);

    conversion_done_req = xie_gate_one(conversion_done_irq_enable,
      flags.conversion_done_flag);

    window_compare_req = xie_gate_one(window_compare_irq_enable,
      flags.window_compare_flag);

    clock_alarm_req = xie_gate_one(clock_alarm_irq_enable, flags.clock_alarm);

    twowire_port_req = xie_gate_one(twowire_port_irq_enable, flags.twowire_port);
  end

  // ==========================================
  // request outputs

  // requests are levels that follow the flags within the same cycle
  always_comb begin
    req.timer_three = timer_three_req;

    req.comparator = comparator_req;

    req.counter_array = counter_array_req;

    req.conversion_done = conversion_done_req;

    req.window_compare = window_compare_req;

    req.clock_alarm = clock_alarm_req;

    req.twowire_port = twowire_port_req;
  end

endmodule : xie_enable_one
`default_nettype wire

/* tb/xie_flag_src.sv */
// peripheral flag sources: level flags that the bench raises and holds
// assumes the bench changes src on the clock edge; flags follow one edge later
`default_nettype none
module xie_flag_src import xie_pkg::*; (input wire logic clock,
  input wire logic [8:0] src, output var xie_flags_s flags);
  timeunit 1ns; timeprecision 1ns;
  always_ff @(posedge clock) flags <= src;
endmodule : xie_flag_src
`default_nettype wire

/* tb/xie_enable_one_assertions.sv */
// checker on xie_enable_one ports; bound from the bench
// assumes one clock and a synchronous active-high reset
`default_nettype none
module xie_enable_one_assertions import xie_pkg::*; (input wire logic clock, rst, sfr_wr, sfr_hit,
  input wire logic [7:0] sfr_addr, sfr_wdata, enable_bits, sfr_rdata,
  input var xie_flags_s flags, input var xie_req_s req);
  wire logic [7:0] e = enable_bits;
  wire logic [8:0] f = flags;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_w; sfr_wr && sfr_addr == 8'hE6 |=> e == ($past(sfr_wdata) & 8'hBF); endproperty
  a_w: assert property (p_w) else $error("write lost");
  property p_k; !(sfr_wr && sfr_addr == 8'hE6) |=> $stable(e); endproperty
  a_k: assert property (p_k) else $error("register changed without write");
  property p_r;
    sfr_rdata == ((sfr_addr == 8'hE6) ? e : 8'h00) && sfr_hit == (sfr_addr == 8'hE6);
  endproperty
  a_r: assert property (p_r) else $error("read path");
  property p_u; e[6] == 1'b0; endproperty
  a_u: assert property (p_u) else $error("unused bit set");
  property p_z; disable iff (1'b0) rst |=> e == 8'h00 && req == 7'h00; endproperty
  a_z: assert property (p_z) else $error("reset value");
  property p_7; req[6] == (e[7] & (f[8] | f[7])); endproperty
  a_7: assert property (p_7) else $error("gate");
  property p_5; req[5] == (e[5] & (f[6] | f[5])); endproperty
  a_5: assert property (p_5) else $error("gate");
  property p_4; req[4] == (e[4] & f[4]); endproperty
  a_4: assert property (p_4) else $error("gate");
  property p_3; req[3] == (e[3] & f[3]); endproperty
  a_3: assert property (p_3) else $error("gate");
  property p_2; req[2] == (e[2] & f[2]); endproperty
  a_2: assert property (p_2) else $error("gate");
  property p_1; req[1] == (e[1] & f[1]); endproperty
  a_1: assert property (p_1) else $error("gate");
  property p_0; req[0] == (e[0] & f[0]); endproperty
  a_0: assert property (p_0) else $error("gate");
  c_w: cover property (sfr_wr && sfr_addr == 8'hE6);
  c_t: cover property (req[6] && !f[8]);
  c_m: cover property (f[0] && !e[0]);
  c_p: cover property (f[5] && !e[5] ##1 req[5]);
endmodule : xie_enable_one_assertions
`default_nettype wire

/* tb/xie_enable_one_bench.sv */
// bench: sfr writes with flag patterns; checks readback and requests
// assumes the flag model delays the flags by one edge, in step with the write
`default_nettype none
module xie_enable_one_bench;
  import xie_pkg::*;
  timeunit 1ns; timeprecision 1ns;
  logic clock = 0, rst = 1, sfr_wr = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
  logic [7:0] enable_bits;
  logic sfr_hit;
  logic [8:0] src = 0;
  xie_flags_s flags;
  xie_req_s req;
  int miscompares = 0, tests_run = 0;
  xie_flag_src xie_flag_src_i (.clock, .src, .flags);
  xie_enable_one xie_enable_one_i (.clock, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_rdata, .sfr_hit, .flags, .req, .enable_bits);
  initial forever #5 clock = ~clock;
  initial begin #2000; miscompares++; complete_run(); end
  task chk(input logic [7:0] s, x);
    tests_run++;
    if (s !== x) begin miscompares++; $display("wrong value at %0t: %h %h", $time, s, x); end
  endtask : chk
  // flags land on the same edge as the write, so req is checked against both
  task wr(input logic [7:0] a, d, input logic [8:0] p, input logic [7:0] x);
    @(posedge clock) {sfr_addr, sfr_wr, sfr_wdata, src} <= {a, 1'b1, d, p};
    @(posedge clock) {sfr_addr, sfr_wr} <= {8'hE6, 1'b0};
    #1 chk(sfr_rdata, x);
    chk(enable_bits, x);
    chk(sfr_hit, 1'b1);
    chk(req, {p[8] | p[7], p[6] | p[5], p[4:0]} & {x[7], x[5:0]});
  endtask : wr
  task complete_run();
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(posedge clock);
    rst <= 0;
    wr(8'hE7, 8'hFF, 9'h1FF, 8'h00);
    for (int i = 0; i < 8; i++)
      wr(8'hE6, 8'h01 << i, 9'h1FF, 8'hBF & (8'h01 << i));
    wr(8'hE6, 8'hFF, 9'h155, 8'hBF);
    wr(8'hE6, 8'hFF, 9'h0AA, 8'hBF);
    @(posedge clock) {rst, sfr_addr} <= {1'b1, 8'hE5};
    @(posedge clock) rst <= 0;
    #1 chk(sfr_rdata, 8'h00);
    chk(sfr_hit, 1'b0);
    chk(enable_bits, 8'h00);
    chk(req, 8'h00);
    wr(8'hE5, 8'hFF, 9'h1FF, 8'h00);
    complete_run();
  end
endmodule : xie_enable_one_bench
bind xie_enable_one xie_enable_one_assertions xie_enable_one_assertions_i (.clock, .rst,
  .sfr_wr, .sfr_hit, .sfr_addr, .sfr_wdata, .enable_bits, .sfr_rdata, .flags, .req);
`default_nettype wire
